/* logic/sms_sequencer.sv */
// sms_sequencer: suspend-mode power sequencer with apb registers and irq.
// assumes apb master synchronous to clock; link pins synchronous to clock.
// Operation
// (RQ1) hardware request honoured only when enabled
// (RQ2) polarity bit selects request active level
// (RQ3) software bit enters and leaves suspend
// (RQ4) hardware suspend refuses host, outputs low
// (RQ5) registers and memory retained through suspend
// (RQ6) slow clock divided or taken external
// (RQ7) refresh type field selects suspend refresh
// (RQ8) block transfer pauses at refresh, resumes
// (RQ9) system requests only after host drained
// (RQ10) after cbr burst switch to slow refresh
// (RQ11) interval, panel down 150 ms, clocks stop
// (RQ12) system may stop slow clock self-refresh only
// (RQ13) status output active only with bit 4
// (RQ14) status low clocks-stop to 32 us after
// (RQ15) suspend ends by its starting mechanism
// (RQ16) resume waits 64 ms for synthesizers
// (RQ17) host restored after last slow refresh
// (RQ18) resume steps vdd, pads, backlight by interval
// (RQ19) interval counter runs on slow clock ticks
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module sms_sequencer
  import sms_pkg::*;
#(
  parameter int PanelDownCyc = PANEL_DOWN_CYC,
  parameter int SynthCyc = SYNTH_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  sms_link_if.dev link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic refreshPulse,
  output logic selfRefreshLow,
  output logic memOutputEnable,
  output logic bltPause,
  output logic panelVdd,
  output logic panelPads,
  output logic panelBacklight,
  output logic clocksRun,
  output logic refClockEnable
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0] cfg_r, cfg_nxt;
  logic swSus_r, swSus_nxt;
  logic [7:0] intv_r, intv_nxt;
  logic [IRQ_W-1:0] irqSt_r, irqSt_nxt, irqEn_r, irqEn_nxt, irqSet;
  sms_state_t st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [8:0] div_r, div_nxt;
  logic [11:0] ref_r, ref_nxt;
  logic [2:0] cbr_r, cbr_nxt;
  logic [11:0] stat_r, stat_nxt;
  logic hwSus_r, hwSus_nxt;
  logic slowPrev_r, slowTick, refTick, hwReq, anyReq, wr;
  logic [31:0] rdWord, prdata_nxt;

  // request level after polarity and enable
  assign hwReq = cfg_r[CFG_HWEN] & (link.suspendRequest ^ cfg_r[CFG_POL]);  // see RQ1 RQ2
  assign anyReq = hwReq | swSus_r;  // see RQ3 RQ15
  // host locked out from hardware suspend entry until the last slow refresh; software suspend keeps the bus
  assign wr = psel & penable & pwrite & ~hwSus_r;  // see RQ4 RQ3
  assign pready = 1'b1;

  // ----------------------------------------
  // slow clock: divider or edge of external input
  // ----------------------------------------
  always_comb
  begin
    div_nxt = (div_r == 9'(SLOW_DIV - 1)) ? 9'h000 : div_r + 9'h001;
    slowTick = cfg_r[CFG_DIV] ? (div_r == 9'(SLOW_DIV - 1))
                               : (link.slowClockInput & ~slowPrev_r);  // see RQ6
  end
  assign refClockEnable = cfg_r[CFG_DIV];  // see RQ6
  // refresh period: 8 ms is 256 ticks, 64 ms is 2048 ticks of 32 kHz
  always_comb
  begin
    ref_nxt = ref_r;
    refTick = 1'b0;
    if (slowTick)
    begin
      if (ref_r == ((cfg_r[1:0] == REF_CBR64) ? 12'h7ff : 12'h0ff))  // see RQ7
      begin
        ref_nxt = 12'h000;
        refTick = 1'b1;
      end
      else
        ref_nxt = ref_r + 12'h001;
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cbr_nxt = cbr_r;
    hwSus_nxt = hwSus_r;
    irqSet = '0;
    case (st_r)
      SMS_RUN:
      begin
        if (anyReq)
        begin
          st_nxt = SMS_REFR;
          hwSus_nxt = hwReq;
          cbr_nxt = 3'h0;
        end
      end
      SMS_REFR:
      begin
        if (cbr_r == 3'(CBR_BURST))  // see RQ10
        begin
          st_nxt = SMS_WAIT;
          cnt_nxt = {24'h0, intv_r};
        end
        else if (slowTick)
          cbr_nxt = cbr_r + 3'h1;
      end
      SMS_WAIT:
      begin
        if (cnt_r == 32'h0)
        begin
          st_nxt = SMS_PDOWN;
          cnt_nxt = 32'(PanelDownCyc);
        end
        else if (slowTick)
          cnt_nxt = cnt_r - 32'h1;  // see RQ19
      end
      SMS_PDOWN:
      begin
        if (cnt_r == 32'h0)
        begin
          st_nxt = SMS_STOP;  // see RQ11
          irqSet[0] = 1'b1;
        end
        else
          cnt_nxt = cnt_r - 32'h1;
      end
      SMS_STOP:
      begin
        if ((hwSus_r & ~hwReq) | (~hwSus_r & ~swSus_r))  // see RQ15
        begin
          st_nxt = SMS_SYNTH;
          cnt_nxt = 32'(SynthCyc);
        end
      end
      SMS_SYNTH:
      begin
        if (cnt_r == 32'h0)
          st_nxt = SMS_LASTREF;  // see RQ16
        else
          cnt_nxt = cnt_r - 32'h1;
      end
      SMS_LASTREF:
      begin
        if (refTick | (cfg_r[1:0] == REF_SELF) | (cfg_r[1:0] == REF_NONE))
        begin
          st_nxt = SMS_VDD;  // see RQ17
          hwSus_nxt = 1'b0;
          cnt_nxt = {24'h0, intv_r};
        end
      end
      SMS_VDD, SMS_PADS, SMS_BL:
      begin
        if (cnt_r == 32'h0)
        begin
          cnt_nxt = {24'h0, intv_r};
          st_nxt = (st_r == SMS_VDD) ? SMS_PADS : (st_r == SMS_PADS) ? SMS_BL : SMS_RUN;
          irqSet[1] = (st_r == SMS_BL);  // see RQ18
        end
        else if (slowTick)
          cnt_nxt = cnt_r - 32'h1;
      end
      default:
        st_nxt = SMS_RUN;
    endcase
  end

  // status low from clock stop until 32 us after restart, and held low through the synthesizer wait and last refresh
  always_comb
  begin
    stat_nxt = stat_r;
    if (st_r == SMS_STOP)
      stat_nxt = 12'(STAT_CYC);
    else if (stat_r != 12'h000)
      stat_nxt = stat_r - 12'h001;  // see RQ14
  end

  // ----------------------------------------
  // register writes and irq
  // ----------------------------------------
  always_comb
  begin
    cfg_nxt = cfg_r;
    swSus_nxt = swSus_r;
    intv_nxt = intv_r;
    irqEn_nxt = irqEn_r;
    irqSt_nxt = irqSt_r;
    if (wr && paddr == OFS_SUSCFG)
      cfg_nxt = pwdata[4:0];
    if (wr && paddr == OFS_PWRCTL)
      swSus_nxt = pwdata[PWR_SWSUS];  // see RQ3
    if (wr && paddr == OFS_PNLINT)
      intv_nxt = pwdata[7:0];
    if (wr && paddr == OFS_IRQEN)
      irqEn_nxt = pwdata[IRQ_W-1:0];
    if (wr && paddr == OFS_IRQCLR)
      irqSt_nxt = irqSt_nxt & ~pwdata[IRQ_W-1:0];
    irqSt_nxt = irqSt_nxt | irqSet;
  end
  assign irq = |(irqSt_r & irqEn_r);

  always_comb
  begin
    rdWord = 32'h0;
    pslverr = 1'b0;
    if (psel & hwSus_r)
      pslverr = 1'b1;  // see RQ4
    else if (psel & ~pwrite)
    begin
      case (paddr)
        OFS_PWRCTL: rdWord = {29'h0, swSus_r, 2'h0};
        OFS_SUSCFG: rdWord = {27'h0, cfg_r};
        OFS_PNLINT: rdWord = {24'h0, intv_r};
        OFS_STATUS: rdWord = {28'h0, st_r};
        OFS_IRQST: rdWord = {30'h0, irqSt_r};
        OFS_IRQEN: rdWord = {30'h0, irqEn_r};
        OFS_IRQCLR: rdWord = 32'h0;
        default: pslverr = 1'b1;
      endcase
    end
    // captured in the setup cycle so the word stands through the access phase
    prdata_nxt = (psel & ~penable & ~pwrite) ? rdWord : prdata;
  end

  // ----------------------------------------
  // outputs; registers held through suspend, never cleared by it
  // ----------------------------------------
  assign link.suspendStatusN = ~cfg_r[CFG_DIV] | (stat_r == 12'h000 && st_r != SMS_STOP
                               && st_r != SMS_SYNTH && st_r != SMS_LASTREF);  // see RQ13 RQ14
  assign link.hostReady = ~hwSus_r;
  assign bltPause = (st_r != SMS_RUN) & (st_r != SMS_REFR | cbr_r != 3'h0);  // see RQ8
  assign refreshPulse = (st_r == SMS_RUN | st_r == SMS_REFR) ? slowTick
                        : (cfg_r[1:0] != REF_SELF && cfg_r[1:0] != REF_NONE) & refTick;
  assign selfRefreshLow = (st_r == SMS_STOP) & (cfg_r[1:0] == REF_SELF);  // see RQ7
  assign memOutputEnable = ~((st_r == SMS_STOP) & (cfg_r[1:0] == REF_NONE));  // see RQ5
  assign clocksRun = (st_r != SMS_STOP);  // see RQ11
  assign panelVdd = (st_r == SMS_RUN) | (st_r == SMS_REFR) | (st_r == SMS_WAIT)
                    | (st_r == SMS_PADS) | (st_r == SMS_BL);
  assign panelPads = (st_r == SMS_RUN) | (st_r == SMS_REFR) | (st_r == SMS_WAIT)
                     | (st_r == SMS_BL);
  assign panelBacklight = (st_r == SMS_RUN) | (st_r == SMS_REFR) | (st_r == SMS_WAIT);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_r <= SUSCFG_RST;
      swSus_r <= 1'b0;
      intv_r <= PNLINT_RST;
      irqSt_r <= '0;
      irqEn_r <= '0;
      st_r <= SMS_RUN;
      cnt_r <= 32'h0;
      div_r <= 9'h000;
      ref_r <= 12'h000;
      cbr_r <= 3'h0;
      stat_r <= 12'h000;
      hwSus_r <= 1'b0;
      slowPrev_r <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      swSus_r <= swSus_nxt;
      intv_r <= intv_nxt;
      irqSt_r <= irqSt_nxt;
      irqEn_r <= irqEn_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      ref_r <= ref_nxt;
      cbr_r <= cbr_nxt;
      stat_r <= stat_nxt;
      hwSus_r <= hwSus_nxt;
      slowPrev_r <= link.slowClockInput;
      prdata <= prdata_nxt;
    end
  end
endmodule : sms_sequencer

/* logic/sms_pkg.sv */
// sms_pkg: constants shared by the suspend sequencer and its power-management partner.
// assumes a single 100 MHz clock.
package sms_pkg;
  // ----------------------------------------
  // apb register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] OFS_PWRCTL = 8'h00;
  localparam logic [7:0] OFS_SUSCFG = 8'h04;
  localparam logic [7:0] OFS_PNLINT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQST = 8'h10;
  localparam logic [7:0] OFS_IRQEN = 8'h14;
  localparam logic [7:0] OFS_IRQCLR = 8'h18;
  localparam logic [7:0] OFS_HREQ = 8'h1c;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CFG_REF_LO = 0;
  localparam int CFG_HWEN = 2;
  localparam int CFG_POL = 3;
  localparam int CFG_DIV = 4;
  localparam int PWR_SWSUS = 2;
  localparam logic [4:0] SUSCFG_RST = 5'h00;
  localparam logic [7:0] PNLINT_RST = 8'h04;
  localparam logic [1:0] REF_CBR8 = 2'h0;
  localparam logic [1:0] REF_CBR64 = 2'h1;
  localparam logic [1:0] REF_SELF = 2'h2;
  localparam logic [1:0] REF_NONE = 2'h3;
  // irq bits: 0 entered suspend, 1 resumed
  localparam int IRQ_W = 2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SLOW_DIV = 432;
  localparam int SLOW_CNT = 3052;
  localparam int STAT_US = 32;
  localparam int STAT_CYC = STAT_US * CLK_MHZ;
  localparam int PANEL_DOWN_MS = 150;
  localparam int PANEL_DOWN_CYC = PANEL_DOWN_MS * 1000 * CLK_MHZ;
  localparam int SYNTH_MS = 64;
  localparam int SYNTH_CYC = SYNTH_MS * 1000 * CLK_MHZ;
  localparam int CBR_BURST = 3;
  typedef enum logic [3:0] {
    SMS_RUN = 4'h0, SMS_REFR = 4'h1, SMS_WAIT = 4'h2, SMS_PDOWN = 4'h3,
    SMS_STOP = 4'h4, SMS_SYNTH = 4'h5, SMS_LASTREF = 4'h6, SMS_VDD = 4'h7,
    SMS_PADS = 4'h8, SMS_BL = 4'h9
  } sms_state_t;
endpackage : sms_pkg

/* logic/sms_link_if.sv */
// sms_link_if: pins between power-management logic and the sequencer.
// assumes both ends share clock.
`timescale 1ns/100ps
interface sms_link_if;
  logic suspendRequest;
  logic suspendStatusN;
  logic slowClockInput;
  logic hostReady;
  modport dev (input suspendRequest, input slowClockInput, output suspendStatusN,
    output hostReady);
  modport sys (output suspendRequest, output slowClockInput, input suspendStatusN,
    input hostReady);
endinterface : sms_link_if

/* logic/sms_power_mgr.sv */
// sms_power_mgr: system power-management end driving the suspend request.
// assumes host drain indication from the user side.
`timescale 1ns/100ps
module sms_power_mgr
  import sms_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  sms_link_if.sys link,
  input wire logic suspendCmd,
  input wire logic activeLow,
  input wire logic slowClockStop,
  output logic suspended
);
  logic req_r, req_nxt;
  logic [8:0] div_r, div_nxt;
  logic slow_r, slow_nxt;

  // ----------------------------------------
  // request: only once the host handshake is idle
  // ----------------------------------------
  always_comb
  begin
    req_nxt = req_r;
    if (suspendCmd & link.hostReady)
      req_nxt = 1'b1;  // see RQ9
    else if (~suspendCmd)
      req_nxt = 1'b0;  // see RQ15
    div_nxt = (div_r == 9'(SLOW_DIV/2 - 1)) ? 9'h000 : div_r + 9'h001;
    slow_nxt = (div_r == 9'(SLOW_DIV/2 - 1)) ? ~slow_r : slow_r;
    // clock may only stop while suspended; restarts once the request is released
    if (slowClockStop & req_r & ~link.suspendStatusN)
      slow_nxt = slow_r;  // see RQ12 RQ16
  end
  assign link.suspendRequest = req_r ^ activeLow;
  assign link.slowClockInput = slow_r;
  assign suspended = ~link.suspendStatusN;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_r <= 1'b0;
      div_r <= 9'h000;
      slow_r <= 1'b0;
    end
    else
    begin
      req_r <= req_nxt;
      div_r <= div_nxt;
      slow_r <= slow_nxt;
    end
  end
endmodule : sms_power_mgr

/* bench/sms_sva.sv */
// sms_sva: assertions on the link and panel pins.
// assumes the bench instantiates it beside the link.
`timescale 1ns/100ps
module sms_sva
  import sms_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic suspendStatusN,
  input wire logic clocksRun,
  input wire logic panelVdd,
  input wire logic panelPads,
  input wire logic panelBacklight,
  input wire logic selfRefreshLow,
  input wire logic memOutputEnable,
  input wire logic bltPause,
  input wire logic refreshPulse,
  input wire logic refClockEnable
);
  // ----
  // cycles since clocks restarted
  // ----
  logic [15:0] runCnt_r;
  logic [15:0] runCnt_nxt;
  // saturates so a long run never wraps back under the window
  always_comb
  begin
    runCnt_nxt = runCnt_r;
    if (!clocksRun)
      runCnt_nxt = 16'h0000;
    else if (runCnt_r != 16'hffff)
      runCnt_nxt = runCnt_r + 16'h0001;
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      runCnt_r <= 16'hffff;
    else
      runCnt_r <= runCnt_nxt;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence s_stop;
    $fell(clocksRun);
  endsequence
  sequence s_vddUp;
    $rose(panelVdd);
  endsequence
  a_status_stop: assert property (!clocksRun && !$past(clocksRun) && refClockEnable
    && $past(refClockEnable) |-> !suspendStatusN) else $error("status high in stop");
  a_status_hold: assert property ($rose(suspendStatusN) && refClockEnable
    && $past(refClockEnable) |-> runCnt_r >= STAT_CYC - 2) else $error("status rose early");
  a_status_idle: assert property (!refClockEnable && !$past(refClockEnable)
    |-> suspendStatusN) else $error("status low while unused");
  a_panel_off: assert property (!clocksRun |-> !panelVdd && !panelPads
    && !panelBacklight) else $error("panel powered in stop");
  a_pads_vdd: assert property ($rose(panelPads) |-> panelVdd)
    else $error("pads before vdd");
  a_light_last: assert property ($rose(panelBacklight) |-> panelPads && panelVdd)
    else $error("backlight too early");
  a_pads_spaced: assert property (s_vddUp |-> !panelPads [*8])
    else $error("pads without interval");
  a_self_stop: assert property (selfRefreshLow |-> !clocksRun)
    else $error("self refresh while running");
  a_mem_float: assert property (!memOutputEnable |-> !clocksRun)
    else $error("memory floated while running");
  a_blt_paused: assert property (s_stop |-> bltPause)
    else $error("transfer not paused");
  a_self_quiet: assert property (selfRefreshLow |-> !refreshPulse)
    else $error("refresh pulse during self refresh");
  a_float_quiet: assert property (!memOutputEnable |-> !refreshPulse)
    else $error("refresh pulse with memory floated");
endmodule : sms_sva

/* bench/suspend_mode_sequencer_bench.sv */
// suspend_mode_sequencer_bench: both ends joined, driven over apb.
// assumes sms_pkg, link, both ends and sms_sva compiled first.
`timescale 1ns/100ps
module suspend_mode_sequencer_bench;
  import sms_pkg::*;
  logic clock, reset_n, psel, penable, pwrite, suspendCmd, activeLow, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, selfRefreshLow, memOutputEnable, bltPause;
  logic panelVdd, panelPads, panelBacklight, clocksRun, refClockEnable;
  logic refreshPulse, suspended;
  int failures = 0;
  int num_checks = 0;
  sms_link_if link ();
  sms_sequencer #(.PanelDownCyc(20), .SynthCyc(20)) sms_sequencer_inst (
    .clock(clock), .reset_n(reset_n), .link(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .refreshPulse(refreshPulse),
    .selfRefreshLow(selfRefreshLow),
    .memOutputEnable(memOutputEnable), .bltPause(bltPause), .panelVdd(panelVdd),
    .panelPads(panelPads), .panelBacklight(panelBacklight), .clocksRun(clocksRun),
    .refClockEnable(refClockEnable));
  // slow clock stop stays low: only the self-refresh power-off path would use it
  sms_power_mgr sms_power_mgr_inst (.clock(clock), .reset_n(reset_n), .link(link),
    .suspendCmd(suspendCmd), .activeLow(activeLow), .slowClockStop(1'h0),
    .suspended(suspended));
  sms_sva sms_sva_inst (.clock(clock), .reset_n(reset_n),
    .suspendStatusN(link.suspendStatusN), .clocksRun(clocksRun), .panelVdd(panelVdd),
    .panelPads(panelPads), .panelBacklight(panelBacklight),
    .selfRefreshLow(selfRefreshLow), .memOutputEnable(memOutputEnable),
    .bltPause(bltPause), .refreshPulse(refreshPulse), .refClockEnable(refClockEnable));
  // ----
  // tasks
  // ----
  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    chk(pready, 1'h1);
    if (pready !== 1'h1)
      end_of_test;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // k 0 watches the clocks, k 1 the backlight
  task waitSig(input int k, input logic v);
    int n;
    n = 0;
    while ((k == 0 ? clocksRun : panelBacklight) !== v)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > 60000)
      begin
        failures++;
        $display("BAD %0t wait ran out", $time);
        end_of_test;
      end
    end
  endtask : waitSig
  task t_reset;
    apb(1'h0, OFS_SUSCFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, OFS_PNLINT, 32'h0);
    chk(rd, 32'h4);
    apb(1'h0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_reset
  task t_software;
    for (int t = 2; t < 4; t++)
    begin
      apb(1'h1, OFS_SUSCFG, 32'h10 | t);
      apb(1'h1, OFS_PNLINT, 32'h5);
      apb(1'h1, OFS_IRQEN, 32'h3);
      apb(1'h1, OFS_PWRCTL, 32'h4);
      waitSig(0, 1'h0);
      chk(selfRefreshLow, t == 2);
      chk(memOutputEnable, t != 3);
      chk({suspended, link.suspendStatusN, refClockEnable, irq}, 4'hb);
      apb(1'h0, OFS_SUSCFG, 32'h0);
      chk(rd, 32'h10 | t);
      apb(1'h1, OFS_PWRCTL, 32'h0);
      waitSig(1, 1'h1);
      chk({link.suspendStatusN, panelPads, panelVdd}, 3'h7);
      apb(1'h1, OFS_IRQEN, 32'h0);
      #1;
      chk(irq, 1'h0);
      apb(1'h0, OFS_IRQST, 32'h0);
      chk(rd, 32'h3);
      apb(1'h1, OFS_IRQCLR, 32'h3);
      apb(1'h0, OFS_IRQST, 32'h0);
      chk(rd, 32'h0);
    end
  endtask : t_software
  // p 0 runs the request active high, p 1 active low
  task t_hardware;
    for (int p = 0; p < 2; p++)
    begin
      apb(1'h1, OFS_PNLINT, 32'h1);
      apb(1'h1, OFS_SUSCFG, 32'(2 + 8 * p));
      activeLow <= (p == 1);
      suspendCmd <= 1'h1;
      repeat (4000) @(posedge clock);
      #1;
      chk({clocksRun, link.hostReady, refClockEnable}, 3'h6);
      apb(1'h1, OFS_SUSCFG, 32'(6 + 8 * p));
      waitSig(0, 1'h0);
      chk({link.hostReady, panelVdd, link.suspendStatusN, suspended}, 4'h2);
      apb(1'h1, OFS_PWRCTL, 32'h4);
      chk(err, 1'h1);
      suspendCmd <= 1'h0;
      waitSig(1, 1'h1);
      chk(link.hostReady, 1'h1);
      apb(1'h0, OFS_PWRCTL, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, OFS_SUSCFG, 32'h0);
      chk(rd, 32'(6 + 8 * p));
    end
  endtask : t_hardware
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    reset_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    suspendCmd = 1'h0;
    activeLow = 1'h0;
    repeat (12) @(posedge clock);
    reset_n <= 1'h1;
    t_reset;
    t_software;
    t_hardware;
    end_of_test;
  end
endmodule : suspend_mode_sequencer_bench
